// ### bench/nand_host_model.sv
`timescale 1ns/1ps
module nand_host_model (
   input  wire logic                clock_i,
   output nand_prog_pkg::nand_bus_t bus_o
);
   logic [7:0] pg = 8'h00;
   logic [7:0] first_byte = 8'h00;
   initial bus_o = '0;
   // A released data line flips, so a stale byte never looks like a fresh one.
   task automatic put(input logic [2:0] k, input logic [7:0] b);
      @(posedge clock_i);
      bus_o <= {k, b};
      @(posedge clock_i);
      bus_o <= {3'h0, ~b};
   endtask
   task automatic prog(input logic [1:0] pl, input logic [7:0] cf);
      int n;
      logic [7:0] b;
      n = $urandom_range(6, 2);
      put(3'h4, nand_prog_pkg::CMD_OPEN);
      for (int i = 0; i < 5; i++) put(3'h2, i == 2 ? pg : (i == 3 ? {6'h00, pl} : 8'h00));
      for (int i = 0; i < n; i++) begin
         if (i == 1) begin
            put(3'h4, nand_prog_pkg::CMD_CHANGE);
            put(3'h2, 8'h08);
            put(3'h2, 8'h00);
         end
         b = 8'($urandom);
         if (i == 0) first_byte = b;
         put(3'h1, b);
      end
      put(3'h4, cf);
      pg = pg + 8'h01;
   endtask
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------
   logic                      clock_i = 1'b0;
   logic                      rstn_i  = 1'b0;
   nand_prog_pkg::nand_bus_t  bus;
   logic [7:0]                st;
   logic                      sv, oe, awr, wr_r, bv, arr, rv;
   logic [3:0]                pm;
   logic [1:0]                br, rr_s;
   logic [31:0]               rd_d, d;
   logic                      awv = 0, wv = 0, bw = 0, arv = 0, rr = 0;
   logic [7:0]                aa = 0, ara = 0;
   logic [31:0]               wd = 0;
   logic [1:0]                r;
   int                        errors = 0, cmp_count = 0, cyc = 0;
   always #50 clock_i = ~clock_i;
   nand_host_model h (.clock_i(clock_i), .bus_o(bus));
   nand_page_program_sequencer #(.PROGRAM_CYCLES(100), .CACHE_BUSY_CYCLES(4)) dut_u (
      .clock_i(clock_i), .rstn_i(rstn_i), .bus_i(bus), .status_o(st), .status_valid_o(sv),
      .rb_o(), .rb_oe_o(oe), .array_planes_o(pm), .awvalid_i(awv), .awready_o(awr),
      .awaddr_i(aa), .wvalid_i(wv), .wready_o(wr_r), .wdata_i(wd), .wstrb_i(4'hf),
      .bvalid_o(bv), .bready_i(bw), .bresp_o(br), .arvalid_i(arv), .arready_o(arr),
      .araddr_i(ara), .rvalid_o(rv), .rready_i(rr), .rdata_o(rd_d), .rresp_o(rr_s));
   function automatic logic [7:0] sr(input logic ready, array_ready, cached_fail, failed);
      return {1'b0, ready, array_ready, 3'h0, cached_fail, failed};
   endfunction
   task automatic chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("FAIL %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Each channel is released on the edge at which its own ready is seen.
   task automatic wrr(input logic [7:0] a, input logic [31:0] v);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      @(posedge clock_i);
      {awv, wv, bw, aa, wd} <= {3'b111, a, v};
      while (!(aw_done && w_done)) begin
         @(posedge clock_i);
         if (!aw_done && awr) begin
            aw_done = 1'b1;
            awv     <= 1'b0;
         end
         if (!w_done && wr_r) begin
            w_done = 1'b1;
            wv     <= 1'b0;
         end
      end
      while (!bv) @(posedge clock_i);
      bw <= 1'b0;
      chk(br, nand_prog_pkg::RESP_OKAY);
   endtask
   task automatic rdr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      @(posedge clock_i);
      {arv, rr, ara} <= {2'b11, a};
      @(posedge clock_i);
      while (!arr) @(posedge clock_i);
      arv <= 1'b0;
      while (!rv) @(posedge clock_i);
      rr <= 1'b0;
      {v, e} = {rd_d, rr_s};
   endtask
   // Three edges first: status trails the confirm by two cycles.
   task automatic wst(input logic [7:0] e);
      int n;
      n = 0;
      // Every look waits past the edge, so the status launched there has settled.
      repeat (3) @(posedge clock_i);
      #1;
      while (st !== e && n < 400) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      chk(st, e);
   endtask
   task automatic summarize;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc > 20000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      void'($urandom(45748));
      repeat (20) @(posedge clock_i);
      rstn_i <= 1'b1;
      wst(sr(1, 1, 0, 0));
      h.prog(2'd1, nand_prog_pkg::CMD_CONFIRM);
      repeat (3) @(posedge clock_i);
      #1 chk({st, oe}, {sr(0, 0, 0, 0), 1'b1});
      h.put(3'h4, nand_prog_pkg::CMD_STATUS_ENH);
      #1 chk(sv, 1'b1);
      h.put(3'h4, nand_prog_pkg::CMD_OPEN);
      rdr(nand_prog_pkg::REG_ILLEGAL, d, r);
      chk(d, 32'h1);
      wst(sr(1, 1, 0, 0));
      chk({pm, oe}, 5'b00100);
      rdr(nand_prog_pkg::REG_PAGES, d, r);
      chk(d, 32'h1);
      wrr(nand_prog_pkg::REG_CTRL, 32'h0100_0000);
      rdr(nand_prog_pkg::REG_PEEK, d, r);
      chk(d, {24'h0, h.first_byte});
      wrr(nand_prog_pkg::REG_CTRL, 32'h010f_0000);
      rdr(nand_prog_pkg::REG_PEEK, d, r);
      chk(d, {24'h0, nand_prog_pkg::ERASED_BYTE});
      rdr(nand_prog_pkg::REG_ROW, d, r);
      chk(d, 32'h0000_0100);
      h.prog(2'd2, nand_prog_pkg::CMD_CACHE);
      repeat (3) @(posedge clock_i);
      #1 chk(st, sr(0, 0, 0, 0));
      wst(sr(1, 0, 0, 0));
      chk(oe, 1'b0);
      h.put(3'h4, nand_prog_pkg::CMD_STATUS);
      #1 chk(sv, 1'b1);
      h.prog(2'd3, nand_prog_pkg::CMD_CACHE);
      wst(sr(1, 0, 0, 0));
      h.prog(2'd0, nand_prog_pkg::CMD_CONFIRM);
      wst(sr(1, 1, 0, 0));
      chk(pm, 4'b0001);
      h.prog(2'd1, nand_prog_pkg::CMD_QUEUE);
      wst(sr(1, 1, 0, 0));
      h.prog(2'd3, nand_prog_pkg::CMD_CONFIRM);
      wst(sr(1, 1, 0, 0));
      chk(pm, 4'b1010);
      h.prog(2'd0, nand_prog_pkg::CMD_QUEUE);
      wst(sr(1, 1, 0, 0));
      h.prog(2'd2, nand_prog_pkg::CMD_CACHE);
      wst(sr(1, 0, 0, 0));
      chk(pm, 4'b0101);
      wst(sr(1, 1, 0, 0));
      wrr(nand_prog_pkg::REG_CTRL, 32'h1);
      h.prog(2'd1, nand_prog_pkg::CMD_CONFIRM);
      wst(sr(1, 1, 0, 1));
      h.prog(2'd2, nand_prog_pkg::CMD_CACHE);
      wst(sr(1, 0, 0, 1));
      wst(sr(1, 1, 1, 1));
      h.put(3'h4, nand_prog_pkg::CMD_RESET);
      wst(sr(1, 1, 0, 0));
      rdr(8'h40, d, r);
      chk({r, d}, {nand_prog_pkg::RESP_SLVERR, 32'h0});
      summarize();
   end
endmodule

// ### pkg/nand_prog_pkg.sv
package nand_prog_pkg;

   // ----------------------------------------------------------------
   // Command bytes, erased byte value and last address cycle
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_OPEN         = 8'h80;
   localparam logic [7:0] CMD_CONFIRM      = 8'h10;
   localparam logic [7:0] CMD_QUEUE        = 8'h11;
   localparam logic [7:0] CMD_CACHE        = 8'h15;
   localparam logic [7:0] CMD_CHANGE       = 8'h85;
   localparam logic [7:0] CMD_STATUS       = 8'h70;
   localparam logic [7:0] CMD_STATUS_FIXED = 8'h71;
   localparam logic [7:0] CMD_STATUS_ENH   = 8'h78;
   localparam logic [7:0] CMD_RESET        = 8'hff;
   localparam logic [7:0] CMD_RESET_SYNC   = 8'hfc;
   localparam logic [7:0] CMD_RESET_LUN    = 8'hfa;
   localparam logic [7:0] ERASED_BYTE      = 8'hff;
   localparam logic [2:0] LAST_ADDR_CYCLE  = 3'h4;

   // ----------------------------------------------------------------
   // Status byte fields
   // ----------------------------------------------------------------
   localparam int SR_FAIL        = 0;
   localparam int SR_CACHED_FAIL = 1;
   localparam int SR_ARRAY_READY = 5;
   localparam int SR_RDY         = 6;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_PAGES   = 8'h08;
   localparam logic [7:0] REG_ROW     = 8'h0c;
   localparam logic [7:0] REG_ILLEGAL = 8'h10;
   localparam logic [7:0] REG_PEEK    = 8'h14;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int CTRL_FAIL_BIT  = 0;
   localparam int CTRL_BYTE_LSB  = 16;
   localparam int CTRL_PLANE_LSB = 24;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS        = 100;
   localparam int ARRAY_PROGRAM_TIME_NS  = 200000;
   localparam int CACHE_BUSY_TIME_NS     = 3000;
   localparam int QUEUE_BUSY_TIME_NS     = 500;
   localparam int ARRAY_PROGRAM_CYCLES   =
      (ARRAY_PROGRAM_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int CACHE_BUSY_CYCLES      =
      (CACHE_BUSY_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int QUEUE_BUSY_CYCLES      =
      (QUEUE_BUSY_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   typedef struct packed {
      logic       cmd_we;
      logic       addr_we;
      logic       data_we;
      logic [7:0] data;
   } nand_bus_t;

endpackage

// ### rtl/busy_timer.sv
`timescale 1ns/1ps
module busy_timer #(
   parameter int W = 16
) (
   input  wire logic         clock_i,
   input  wire logic         rstn_i,
   input  wire logic         clear_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] count_i,
   output logic              busy_o,
   output logic              done_o
);

   logic [W-1:0] remain;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         remain <= '0;
      end else if (clear_i) begin
         remain <= '0;
      end else if (load_i) begin
         remain <= count_i;
      end else if (remain != '0) begin
         remain <= remain - 1'b1;
      end
   end

   assign busy_o = remain != '0;
   assign done_o = (remain == W'(1)) && !clear_i && !load_i;

endmodule

// ### rtl/nand_page_program_sequencer.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module nand_page_program_sequencer #(
   parameter int PLANES            = 4,
   parameter int CACHE_BYTES       = 16,
   parameter int PAGE_BITS         = 8,
   parameter int PROGRAM_CYCLES    = nand_prog_pkg::ARRAY_PROGRAM_CYCLES,
   parameter int CACHE_BUSY_CYCLES = nand_prog_pkg::CACHE_BUSY_CYCLES,
   parameter int QUEUE_BUSY_CYCLES = nand_prog_pkg::QUEUE_BUSY_CYCLES
) (
   input  wire logic                      clock_i,
   input  wire logic                      rstn_i,
   input  wire nand_prog_pkg::nand_bus_t  bus_i,
   output logic [7:0]                     status_o,
   output logic                           status_valid_o,
   output logic                           rb_o,
   output logic                           rb_oe_o,
   output logic [PLANES-1:0]              array_planes_o,
   input  wire logic                      awvalid_i,
   output logic                           awready_o,
   input  wire logic [7:0]                awaddr_i,
   input  wire logic                      wvalid_i,
   output logic                           wready_o,
   input  wire logic [31:0]               wdata_i,
   input  wire logic [3:0]                wstrb_i,
   output logic                           bvalid_o,
   input  wire logic                      bready_i,
   output logic [1:0]                     bresp_o,
   input  wire logic                      arvalid_i,
   output logic                           arready_o,
   input  wire logic [7:0]                araddr_i,
   output logic                           rvalid_o,
   input  wire logic                      rready_i,
   output logic [31:0]                    rdata_o,
   output logic [1:0]                     rresp_o
);

   localparam int PB = $clog2(PLANES);
   localparam int CB = $clog2(CACHE_BYTES);

   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_DATA, S_CHANGE, S_WAIT, S_PROG_BUSY} seq_state_t;
   typedef enum logic [1:0] {K_PROG, K_CACHE, K_QUEUE} confirm_kind_t;

   seq_state_t    state;
   confirm_kind_t kind;
   logic [2:0]    addr_cnt;
   logic [15:0]   col;
   logic [23:0]   row;
   logic [PLANES-1:0] queue_mask;
   logic          queued;
   logic [15:0]   illegal;
   logic [15:0]   pages;
   logic          fail;
   logic          fail_c;
   logic [31:0]   ctrl;
   logic          if_busy;
   logic          array_busy;
   logic          array_done;
   logic          rdy;
   logic          array_ready_flag;
   logic [PLANES-1:0] plane_bit;
   logic [PLANES-1:0] next_array_mask;
   logic [7:0]    plane_peek [PLANES];

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   logic cmd_status, cmd_reset, cmd_open, cmd_confirm, cmd_cache, cmd_queue, cmd_change;
   logic clear_cache, write_en, start_array, confirm_any;

   always_comb begin
      cmd_status  = bus_i.cmd_we && (bus_i.data == nand_prog_pkg::CMD_STATUS ||
                    bus_i.data == nand_prog_pkg::CMD_STATUS_FIXED ||
                    bus_i.data == nand_prog_pkg::CMD_STATUS_ENH);
      cmd_reset   = bus_i.cmd_we && (bus_i.data == nand_prog_pkg::CMD_RESET ||
                    bus_i.data == nand_prog_pkg::CMD_RESET_SYNC ||
                    bus_i.data == nand_prog_pkg::CMD_RESET_LUN);
      cmd_open    = bus_i.cmd_we && bus_i.data == nand_prog_pkg::CMD_OPEN;
      cmd_confirm = bus_i.cmd_we && bus_i.data == nand_prog_pkg::CMD_CONFIRM;
      cmd_cache   = bus_i.cmd_we && bus_i.data == nand_prog_pkg::CMD_CACHE;
      cmd_queue   = bus_i.cmd_we && bus_i.data == nand_prog_pkg::CMD_QUEUE;
      cmd_change  = bus_i.cmd_we && bus_i.data == nand_prog_pkg::CMD_CHANGE;
      plane_bit   = '0;
      plane_bit[row[PAGE_BITS +: PB]] = 1'b1;
   end

   // Ready only while no confirm is being worked off; array ready needs both.
   assign rdy  = state != S_WAIT && state != S_PROG_BUSY;
   assign array_ready_flag = rdy && !array_busy;
   assign confirm_any = state == S_DATA && (cmd_confirm || cmd_cache || cmd_queue);
   assign clear_cache = state == S_IDLE && cmd_open && !queued;
   assign write_en    = bus_i.data_we && (state == S_DATA || state == S_CHANGE) &&
                        col < 16'(CACHE_BYTES);
   // A cached confirm waits both its own busy interval and the earlier array write.
   assign start_array = state == S_WAIT && kind != K_QUEUE && !array_busy &&
                        (kind == K_PROG || !if_busy);
   assign next_array_mask = queue_mask | plane_bit;

   // ----------------------------------------------------------------
   // Sequence control
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state      <= S_IDLE;
         kind       <= K_PROG;
         addr_cnt   <= '0;
         col        <= '0;
         row        <= '0;
         queue_mask <= '0;
         queued     <= 1'b0;
         illegal    <= '0;
      end else if (cmd_reset) begin
         state      <= S_IDLE;
         queue_mask <= '0;
         queued     <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (cmd_open) begin
                  state    <= S_ADDR;
                  addr_cnt <= '0;
               end else if (bus_i.cmd_we && !cmd_status) begin
                  illegal <= illegal + 1'b1;
               end
            end
            S_ADDR, S_CHANGE: begin
               if (bus_i.addr_we) begin
                  case (addr_cnt)
                     3'h0: col[7:0]   <= bus_i.data;
                     3'h1: col[15:8]  <= bus_i.data;
                     3'h2: row[7:0]   <= bus_i.data;
                     3'h3: row[15:8]  <= bus_i.data;
                     default: row[23:16] <= bus_i.data;
                  endcase
                  addr_cnt <= addr_cnt + 1'b1;
                  if (state == S_ADDR && addr_cnt == nand_prog_pkg::LAST_ADDR_CYCLE) begin
                     state <= S_DATA;
                  end
               end else if (state == S_CHANGE && bus_i.data_we) begin
                  state <= S_DATA;
                  col   <= col + 1'b1;
               end else if (bus_i.cmd_we && !cmd_status) begin
                  illegal <= illegal + 1'b1;
               end
            end
            S_DATA: begin
               if (bus_i.data_we) begin
                  col <= col + 1'b1;
               end
               if (cmd_change) begin
                  state    <= S_CHANGE;
                  addr_cnt <= '0;
               end else if (confirm_any) begin
                  state <= S_WAIT;
                  // The confirm byte alone tells a plain program from a cached one.
                  kind  <= cmd_confirm ? K_PROG : (cmd_cache ? K_CACHE : K_QUEUE);
                  if (cmd_queue) begin
                     queue_mask <= next_array_mask;
                  end
               end else if (bus_i.cmd_we && !cmd_status) begin
                  illegal <= illegal + 1'b1;
               end
            end
            S_WAIT: begin
               if (kind == K_QUEUE && !if_busy) begin
                  state  <= S_IDLE;
                  queued <= 1'b1;
               end else if (start_array) begin
                  state      <= kind == K_PROG ? S_PROG_BUSY : S_IDLE;
                  queue_mask <= '0;
                  queued     <= 1'b0;
               end
               if (bus_i.cmd_we && !cmd_status) begin
                  illegal <= illegal + 1'b1;
               end
            end
            S_PROG_BUSY: begin
               if (array_done) begin
                  state <= S_IDLE;
               end
               if (bus_i.cmd_we && !cmd_status) begin
                  illegal <= illegal + 1'b1;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Busy timers
   // ----------------------------------------------------------------
   busy_timer #(.W(16)) u_if_timer (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .clear_i (cmd_reset),
      .load_i  (confirm_any && !cmd_confirm),
      .count_i (cmd_cache ? 16'(CACHE_BUSY_CYCLES) : 16'(QUEUE_BUSY_CYCLES)),
      .busy_o  (if_busy),
      .done_o  ()
   );

   busy_timer #(.W(16)) u_array_timer (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .clear_i (cmd_reset),
      .load_i  (start_array),
      .count_i (16'(PROGRAM_CYCLES)),
      .busy_o  (array_busy),
      .done_o  (array_done)
   );

   // ----------------------------------------------------------------
   // Array result and status
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         array_planes_o <= '0;
         fail           <= 1'b0;
         fail_c         <= 1'b0;
         pages          <= '0;
      end else if (cmd_reset) begin
         array_planes_o <= '0;
         fail           <= 1'b0;
         fail_c         <= 1'b0;
      end else if (start_array) begin
         array_planes_o <= next_array_mask;
      end else if (array_done) begin
         fail_c <= fail;
         fail   <= ctrl[nand_prog_pkg::CTRL_FAIL_BIT];
         pages  <= pages + 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         status_o       <= '0;
         status_valid_o <= 1'b0;
         rb_oe_o        <= 1'b0;
      end else begin
         status_o                                <= '0;
         status_o[nand_prog_pkg::SR_RDY]         <= rdy;
         status_o[nand_prog_pkg::SR_ARRAY_READY] <= array_ready_flag;
         status_o[nand_prog_pkg::SR_CACHED_FAIL] <= fail_c;
         status_o[nand_prog_pkg::SR_FAIL]        <= fail;
         status_valid_o                          <= cmd_status;
         rb_oe_o                                 <= !rdy;
      end
   end

   assign rb_o = 1'b0;

   // ----------------------------------------------------------------
   // Cache and data registers per plane
   // ----------------------------------------------------------------
   for (genvar p = 0; p < PLANES; p++) begin : g_plane
      logic [7:0] cache_row [CACHE_BYTES];
      logic [7:0] data_row  [CACHE_BYTES];
      always_ff @(posedge clock_i) begin
         if (clear_cache) begin
            for (int i = 0; i < CACHE_BYTES; i++) begin
               cache_row[i] <= nand_prog_pkg::ERASED_BYTE;
            end
         end else if (write_en && plane_bit[p]) begin
            cache_row[col[CB-1:0]] <= bus_i.data;
         end
         if (start_array && next_array_mask[p]) begin
            data_row <= cache_row;
         end
      end
      assign plane_peek[p] = data_row[ctrl[nand_prog_pkg::CTRL_BYTE_LSB +: CB]];
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic       aw_have, w_have;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   assign awready_o = !aw_have && !bvalid_o;
   assign wready_o  = !w_have && !bvalid_o;
   assign arready_o = !rvalid_o;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_have  <= 1'b0;
         w_have   <= 1'b0;
         aw_addr  <= '0;
         w_data   <= '0;
         w_strb   <= '0;
         bvalid_o <= 1'b0;
         bresp_o  <= nand_prog_pkg::RESP_OKAY;
         ctrl     <= nand_prog_pkg::CTRL_RESET;
      end else begin
         if (awvalid_i && awready_o) begin
            aw_have <= 1'b1;
            aw_addr <= awaddr_i;
         end
         if (wvalid_i && wready_o) begin
            w_have <= 1'b1;
            w_data <= wdata_i;
            w_strb <= wstrb_i;
         end
         if (aw_have && w_have) begin
            aw_have  <= 1'b0;
            w_have   <= 1'b0;
            bvalid_o <= 1'b1;
            bresp_o  <= nand_prog_pkg::RESP_OKAY;
            if (aw_addr == nand_prog_pkg::REG_CTRL) begin
               for (int b = 0; b < 4; b++) begin
                  if (w_strb[b]) begin
                     ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
                  end
               end
            end else if (aw_addr != nand_prog_pkg::REG_STATUS &&
                         aw_addr != nand_prog_pkg::REG_PAGES &&
                         aw_addr != nand_prog_pkg::REG_ROW &&
                         aw_addr != nand_prog_pkg::REG_ILLEGAL &&
                         aw_addr != nand_prog_pkg::REG_PEEK) begin
               bresp_o <= nand_prog_pkg::RESP_SLVERR;
            end
         end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rvalid_o <= 1'b0;
         rdata_o  <= '0;
         rresp_o  <= nand_prog_pkg::RESP_OKAY;
      end else if (arvalid_i && arready_o) begin
         rvalid_o <= 1'b1;
         rresp_o  <= nand_prog_pkg::RESP_OKAY;
         case (araddr_i)
            nand_prog_pkg::REG_CTRL:    rdata_o <= ctrl;
            nand_prog_pkg::REG_STATUS:  rdata_o <= {21'h0, state, status_o};
            nand_prog_pkg::REG_PAGES:   rdata_o <= {16'h0, pages};
            nand_prog_pkg::REG_ROW:     rdata_o <= {8'h0, row};
            nand_prog_pkg::REG_ILLEGAL: rdata_o <= {16'h0, illegal};
            nand_prog_pkg::REG_PEEK:
               rdata_o <= {24'h0, plane_peek[ctrl[nand_prog_pkg::CTRL_PLANE_LSB +: PB]]};
            default: begin
               rdata_o <= '0;
               rresp_o <= nand_prog_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_o && rready_i) begin
         rvalid_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   property p_prog_busy;
      (state == S_DATA && cmd_confirm) |=> !rdy && !array_ready_flag;
   endproperty
   a_prog_busy: assert property (p_prog_busy) else $error("Confirm left ready.");

   property p_prog_hold;
      (state == S_PROG_BUSY) |-> array_busy && !status_o[nand_prog_pkg::SR_ARRAY_READY] [*1]
         ##1 !status_o[nand_prog_pkg::SR_RDY];
   endproperty
   a_prog_hold: assert property (p_prog_hold) else $error("Ready during program.");

   property p_cache_release;
      (start_array && kind == K_CACHE && !cmd_reset) |=> rdy && !array_ready_flag ##1
         status_o[nand_prog_pkg::SR_RDY] && !status_o[nand_prog_pkg::SR_ARRAY_READY];
   endproperty
   a_cache_release: assert property (p_cache_release) else $error("Bad cache phase.");

   property p_cache_busy;
      (state == S_DATA && cmd_cache) |=> !rdy [*3];
   endproperty
   a_cache_busy: assert property (p_cache_busy) else $error("Cache busy too short.");

   property p_rb_low;
      $fell(rdy) |=> rb_oe_o && !rb_o;
   endproperty
   a_rb_low: assert property (p_rb_low) else $error("Busy line not pulled low.");

   property p_rb_high;
      $rose(rdy) |=> !rb_oe_o;
   endproperty
   a_rb_high: assert property (p_rb_high) else $error("Busy line held low.");

   property p_fail_bit;
      (array_done && ctrl[nand_prog_pkg::CTRL_FAIL_BIT] && !cmd_reset) |=> ##1
         status_o[nand_prog_pkg::SR_FAIL];
   endproperty
   a_fail_bit: assert property (p_fail_bit) else $error("Fail bit not shown.");

   property p_clear;
      clear_cache |=> g_plane[0].cache_row[0] == nand_prog_pkg::ERASED_BYTE;
   endproperty
   a_clear: assert property (p_clear) else $error("Cache not cleared.");

   property p_accept;
      (state == S_IDLE && cmd_open) |=> state == S_ADDR;
   endproperty
   a_accept: assert property (p_accept) else $error("Opening byte refused.");

   property p_busy_refuse;
      (state == S_PROG_BUSY && !array_done && bus_i.cmd_we && !cmd_reset) |=>
         state == S_PROG_BUSY;
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("Busy took command.");

endmodule
